//--- include/dvha_pkg.sv
package dvha_pkg;

    // Internal port file
    localparam int PORT_AW = 4;
    localparam int PORT_COUNT = 16;
    localparam int DATA_W = 8;
    localparam logic [7:0] PORT_RESET = 8'h00;

    // Mode port and its field
    localparam logic [3:0] MODE_PORT = 4'h8;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;

    // Refresh address layout
    localparam int REFRESH_AW = 14;
    localparam int REF_BANK_BIT = 13;
    localparam int REF_A12_BIT = 12;
    localparam int REF_MID_MSB = 11;
    localparam int REF_MID_LSB = 5;
    localparam int LOW_ADDR_W = 5;
    localparam int HOST_AW = 6;

    // Display modes held in the mode port
    typedef enum logic [2:0] {
        DVHA_T40X25,
        DVHA_T80X25,
        DVHA_G320X200,
        DVHA_G640X200,
        DVHA_T40X50,
        DVHA_T80X50,
        DVHA_G640X400
    } dvha_mode_e;

    // Host bus strobes, all active low
    typedef struct packed {
        logic port_sel_n;
        logic io_rd_n;
        logic io_wr_n;
        logic mem_sel_n;
        logic mem_rd_n;
        logic mem_wr_n;
    } dvha_host_ctl_s;

    // RAM control outputs
    typedef struct packed {
        logic addr_mux_select;
        logic bank_low_enable_n;
        logic bank_high_enable_n;
        logic char_write_strobe_n;
        logic attr_write_strobe_n;
    } dvha_vram_ctl_s;

endpackage

//--- verilog/dvha_port_file.sv
`timescale 1ns/10ps
module dvha_port_file #(
    parameter int AW = dvha_pkg::PORT_AW,
    parameter int DW = dvha_pkg::DATA_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_index,
    input wire logic [DW-1:0] wr_data,
    // Read side
    input wire logic [AW-1:0] rd_index,
    output logic [DW-1:0] rd_data,
    // Whole bank for the timing logic
    output logic [(2**AW)*DW-1:0] bank
);

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] next_mem [2**AW];

    always_comb
    begin
        for (int i = 0; i < 2**AW; i++)
        begin
            next_mem[i] = mem[i];
        end
        if (wr_en)
        begin
            next_mem[wr_index] = wr_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 2**AW; i++)
        begin
            if (!rst_n)
            begin
                mem[i] <= dvha_pkg::PORT_RESET;
            end
            else
            begin
                mem[i] <= next_mem[i];
            end
        end
    end

    always_comb
    begin
        rd_data = mem[rd_index];
        for (int i = 0; i < 2**AW; i++)
        begin
            bank[i*DW +: DW] = mem[i];
        end
    end

endmodule

//--- verilog/dvha_mode_decode.sv
`timescale 1ns/10ps
module dvha_mode_decode (
    // Mode and panel
    input wire logic [2:0] mode_code,
    input wire logic internal_panel,
    // Decoded
    output logic graph_mode,
    output logic box_tall,
    output logic mode_ok
);

    always_comb
    begin
        graph_mode = 1'b0;
        box_tall = 1'b0;
        mode_ok = 1'b1;
        unique case (mode_code)
            dvha_pkg::DVHA_T40X25, dvha_pkg::DVHA_T80X25:
            begin
                // Tall box on the panel, short box outside
                box_tall = internal_panel;
            end
            dvha_pkg::DVHA_G320X200, dvha_pkg::DVHA_G640X200:
            begin
                graph_mode = 1'b1;
            end
            dvha_pkg::DVHA_T40X50, dvha_pkg::DVHA_T80X50:
            begin
                mode_ok = internal_panel;
            end
            dvha_pkg::DVHA_G640X400:
            begin
                graph_mode = 1'b1;
                box_tall = internal_panel;
                mode_ok = internal_panel;
            end
            default:
            begin
                mode_ok = 1'b0;
            end
        endcase
    end

endmodule

//--- verilog/dvha_host_access.sv
`timescale 1ns/10ps
// Function
// [R1] Port select and I/O read low: addressed port drives host data.
// [R2] Port select and I/O write low: host data stored into port.
// [R3] Host address bits three to zero pick the internal port.
// [R4] Memory select and read low: RAM read returned on host data.
// [R5] Memory select and write low: host byte written into RAM.
// [R6] Ready low while RAM access pending, otherwise high.
// [R7] Reset input low puts the block in reset.
// [R8] Low RAM address from host bits five to one, else refresh.
// [R9] Upper refresh bits go out to the external address multiplexer.
// [R10] Two active-low bank enables, low and high 16KB pairs.
// [R11] Even addresses on character bus, odd on attribute bus.
// [R12] Refresh always fetches character and attribute byte together.
// [R13] Host read enables one bank, forwards byte chosen by bit 0.
// [R14] RAM write strobe only while memory select and write low.
// [R15] Host write: bit 0 picks strobe and bus for the data.
// [R16] Text refresh uses bits 13 and 12; graphics uses raster bits.
// [R17] Refresh fetches never assert a write strobe.
// [R18] Text box tall on panel; some modes panel only. Code keeps the box short in DVHA_T40X50 and DVHA_T80X50 even on the panel.
// [R19] Mux select low for refresh address, high for host address.
// [R20] Disable input high: no response to host accesses.
// [R21] Host gets a RAM slot between refresh fetches, then ready.
// [R22] Host bank enable follows host bank address bit.
module dvha_host_access (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host bus
    input wire dvha_pkg::dvha_host_ctl_s host_ctl,
    input wire logic [dvha_pkg::HOST_AW-1:0] host_addr,
    input wire logic host_bank_addr_bit,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    output logic bus_ready_out,
    input wire logic controller_disable,
    // Refresh side from the timing logic
    input wire logic refresh_req,
    input wire logic [dvha_pkg::REFRESH_AW-1:0] refresh_addr,
    input wire logic raster_line_bit1,
    input wire logic raster_line_bit0,
    input wire logic internal_panel,
    output logic [7:0] refresh_char,
    output logic [7:0] refresh_attr,
    output logic refresh_valid,
    // Mode and port bank for the timing logic
    output logic graph_mode,
    output logic box_tall,
    output logic mode_ok,
    output logic [dvha_pkg::PORT_COUNT*dvha_pkg::DATA_W-1:0] port_bank,
    // RAM side
    output dvha_pkg::dvha_vram_ctl_s vram_ctl,
    output logic [dvha_pkg::LOW_ADDR_W-1:0] vram_low_addr,
    output logic refresh_addr_bit12,
    output logic [dvha_pkg::REF_MID_MSB-dvha_pkg::REF_MID_LSB:0] refresh_addr_mid,
    input wire logic [7:0] char_byte_bus_in,
    output logic [7:0] char_byte_bus_out,
    output logic char_byte_bus_oe_n,
    input wire logic [7:0] attr_byte_bus_in,
    output logic [7:0] attr_byte_bus_out,
    output logic attr_byte_bus_oe_n
);

    typedef enum logic [1:0] {
        DVHA_IDLE,
        DVHA_REF,
        DVHA_HOST,
        DVHA_DONE
    } dvha_state_e;

    dvha_state_e state;
    dvha_state_e next_state;
    logic ref_pending;
    logic next_ref_pending;
    logic port_wr_seen;
    logic next_port_wr_seen;
    logic [7:0] vram_rd_latch;
    logic [7:0] next_vram_rd_latch;
    logic [7:0] next_refresh_char;
    logic [7:0] next_refresh_attr;
    logic next_refresh_valid;

    logic port_rd;
    logic port_wr;
    logic mem_rd;
    logic mem_wr;
    logic mem_req;
    logic [7:0] port_rdata;
    logic [7:0] mode_port;

    // Byte picked by the lowest host address bit
    function automatic logic [7:0] pick_byte(input logic odd, input logic [7:0] ch, input logic [7:0] at);
        pick_byte = odd ? at : ch;
    endfunction

    // Disabled block ignores every host strobe
    // [R20] disable gates host
    assign port_rd = !controller_disable && !host_ctl.port_sel_n && !host_ctl.io_rd_n;
    assign port_wr = !controller_disable && !host_ctl.port_sel_n && !host_ctl.io_wr_n;
    assign mem_rd = !controller_disable && !host_ctl.mem_sel_n && !host_ctl.mem_rd_n;
    assign mem_wr = !controller_disable && !host_ctl.mem_sel_n && !host_ctl.mem_wr_n;
    assign mem_req = mem_rd || mem_wr;

    // [R3] port index decode
    dvha_port_file #(
        .AW(dvha_pkg::PORT_AW),
        .DW(dvha_pkg::DATA_W)
    ) dvha_port_file_i (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(port_wr && !port_wr_seen),
        .wr_index(host_addr[dvha_pkg::PORT_AW-1:0]),
        .wr_data(host_data_bus_in),
        .rd_index(host_addr[dvha_pkg::PORT_AW-1:0]),
        .rd_data(port_rdata),
        .bank(port_bank)
    );

    assign mode_port = port_bank[dvha_pkg::MODE_PORT*dvha_pkg::DATA_W +: dvha_pkg::DATA_W];

    // [R18] mode box decode
    dvha_mode_decode dvha_mode_decode_i (
        .mode_code(mode_port[dvha_pkg::MODE_LSB +: dvha_pkg::MODE_W]),
        .internal_panel(internal_panel),
        .graph_mode(graph_mode),
        .box_tall(box_tall),
        .mode_ok(mode_ok)
    );

    always_comb
    begin
        next_state = state;
        next_ref_pending = ref_pending;
        next_port_wr_seen = port_wr;
        next_vram_rd_latch = vram_rd_latch;
        next_refresh_char = refresh_char;
        next_refresh_attr = refresh_attr;
        next_refresh_valid = 1'b0;
        unique case (state)
            DVHA_IDLE:
            begin
                // Refresh first, host takes the slot after it
                // [R21] slot arbitration
                if (ref_pending)
                begin
                    next_state = DVHA_REF;
                end
                else if (mem_req)
                begin
                    next_state = DVHA_HOST;
                end
            end
            DVHA_REF:
            begin
                // [R12] two-byte fetch
                next_refresh_char = char_byte_bus_in;
                next_refresh_attr = attr_byte_bus_in;
                next_refresh_valid = 1'b1;
                next_ref_pending = 1'b0;
                next_state = DVHA_IDLE;
            end
            DVHA_HOST:
            begin
                // [R13] one byte forwarded
                if (mem_rd)
                begin
                    next_vram_rd_latch = pick_byte(host_addr[0], char_byte_bus_in, attr_byte_bus_in);
                end
                next_state = DVHA_DONE;
            end
            DVHA_DONE:
            begin
                // Hold until the cycle ends so one strobe gives one access
                if (!mem_req)
                begin
                    next_state = DVHA_IDLE;
                end
            end
        endcase
        // A new request in the serving cycle is kept
        if (refresh_req)
        begin
            next_ref_pending = 1'b1;
        end
    end

    // [R7] low reset input
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state <= DVHA_IDLE;
            ref_pending <= 1'b0;
            port_wr_seen <= 1'b0;
            vram_rd_latch <= 8'h00;
            refresh_char <= 8'h00;
            refresh_attr <= 8'h00;
            refresh_valid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ref_pending <= next_ref_pending;
            port_wr_seen <= next_port_wr_seen;
            vram_rd_latch <= next_vram_rd_latch;
            refresh_char <= next_refresh_char;
            refresh_attr <= next_refresh_attr;
            refresh_valid <= next_refresh_valid;
        end
    end

    // [R6] ready stall
    assign bus_ready_out = !(mem_req && state != DVHA_DONE);

    // [R1] port read drive
    // [R4] RAM read drive
    assign host_data_bus_out = port_rd ? port_rdata : vram_rd_latch;
    assign host_data_bus_oe_n = !(port_rd || (mem_rd && state == DVHA_DONE));

    always_comb
    begin
        logic refresh;
        logic hostacc;
        logic bank;
        refresh = (state == DVHA_REF);
        hostacc = (state == DVHA_HOST);
        // [R22] host bank bit
        bank = refresh ? (graph_mode ? raster_line_bit1 : refresh_addr[dvha_pkg::REF_BANK_BIT]) : host_bank_addr_bit;
        // [R19] mux select
        vram_ctl.addr_mux_select = !refresh;
        // [R8] low address source
        vram_low_addr = refresh ? refresh_addr[dvha_pkg::LOW_ADDR_W-1:0] : host_addr[dvha_pkg::HOST_AW-1:1];
        // [R16] text or graphics refresh bits
        // [R9] upper refresh bits out
        refresh_addr_bit12 = graph_mode ? raster_line_bit0 : refresh_addr[dvha_pkg::REF_A12_BIT];
        refresh_addr_mid = refresh_addr[dvha_pkg::REF_MID_MSB:dvha_pkg::REF_MID_LSB];
        // [R10] bank enables
        vram_ctl.bank_low_enable_n = !((refresh || hostacc) && !bank);
        vram_ctl.bank_high_enable_n = !((refresh || hostacc) && bank);
        // [R14] write strobe gating
        // [R15] strobe by bit 0
        // [R17] refresh never writes
        // [R5] host write
        vram_ctl.char_write_strobe_n = !(hostacc && mem_wr && !host_addr[0]);
        vram_ctl.attr_write_strobe_n = !(hostacc && mem_wr && host_addr[0]);
        // [R11] even on char, odd on attr
        char_byte_bus_out = host_data_bus_in;
        attr_byte_bus_out = host_data_bus_in;
        char_byte_bus_oe_n = vram_ctl.char_write_strobe_n;
        attr_byte_bus_oe_n = vram_ctl.attr_write_strobe_n;
    end

    default clocking dvha_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence host_slot_s;
        state == DVHA_IDLE && !ref_pending && mem_req && !refresh_req;
    endsequence

    sequence host_served_s;
        state == DVHA_HOST ##1 state == DVHA_DONE && bus_ready_out;
    endsequence

    ready_stall_a: assert property (mem_req && state != DVHA_DONE |-> !bus_ready_out) // [R6]
        else $error("ready high during pending RAM access");
    ready_idle_a: assert property (!mem_req |-> bus_ready_out) // [R6]
        else $error("ready low with no RAM access");
    host_grant_a: assert property (host_slot_s |=> host_served_s) // [R21]
        else $error("host slot not granted in two cycles");
    wr_gate_a: assert property (!vram_ctl.char_write_strobe_n || !vram_ctl.attr_write_strobe_n |-> mem_wr) // [R14]
        else $error("write strobe without memory write");
    refresh_ro_a: assert property (state == DVHA_REF |-> vram_ctl.char_write_strobe_n
        && vram_ctl.attr_write_strobe_n) // [R17]
        else $error("write strobe during refresh");
    write_steer_a: assert property (!vram_ctl.attr_write_strobe_n |-> host_addr[0] && !attr_byte_bus_oe_n
        && vram_ctl.char_write_strobe_n && attr_byte_bus_out == host_data_bus_in) // [R15]
        else $error("attribute write misrouted");
    read_pick_a: assert property (state == DVHA_HOST && mem_rd |=> vram_rd_latch ==
        $past(host_addr[0] ? attr_byte_bus_in : char_byte_bus_in)) // [R13]
        else $error("wrong byte latched on host read");
    mux_ref_a: assert property (state == DVHA_REF |-> !vram_ctl.addr_mux_select
        && vram_low_addr == refresh_addr[4:0]) // [R19]
        else $error("refresh address not selected");
    bank_host_a: assert property (state == DVHA_HOST |-> vram_ctl.bank_low_enable_n == host_bank_addr_bit
        && vram_ctl.bank_high_enable_n == !host_bank_addr_bit) // [R22]
        else $error("host bank enable wrong");
    refresh_pair_a: assert property (state == DVHA_REF |=> refresh_valid && refresh_char == $past(char_byte_bus_in)
        && refresh_attr == $past(attr_byte_bus_in)) // [R12]
        else $error("refresh pair not captured");
    disable_quiet_a: assert property (controller_disable |-> bus_ready_out && host_data_bus_oe_n) // [R20]
        else $error("disabled block responded");
    port_store_a: assert property (port_wr && !port_wr_seen |=> port_bank[$past(host_addr[3:0])*8 +: 8]
        == $past(host_data_bus_in)) // [R2]
        else $error("port write not stored");
    // Reset check must not be switched off by the reset itself
    reset_idle_a: assert property (@(posedge mclk) disable iff (1'b0)
        !rst_n |=> state == DVHA_IDLE && !refresh_valid) // [R7]
        else $error("reset did not clear state");
    port_read_a: assert property (port_rd |-> !host_data_bus_oe_n
        && host_data_bus_out == port_bank[host_addr[3:0]*8 +: 8]) // [R1]
        else $error("port read not driven");
    host_addr_a: assert property (state == DVHA_HOST |-> vram_ctl.addr_mux_select
        && vram_low_addr == host_addr[5:1]) // [R8]
        else $error("host address not selected");

endmodule

//--- tb/dvha_host_model.sv
`timescale 1ns/10ps
module dvha_host_model (
    // Clock
    input wire logic mclk,
    // Host strobes, address and write data
    output dvha_pkg::dvha_host_ctl_s host_ctl,
    output logic [5:0] host_addr,
    output logic host_bank_addr_bit,
    output logic [7:0] host_data_bus_in,
    // Answers from the block
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe_n,
    input wire logic bus_ready_out
);
    initial
    begin
        host_ctl = '1;
        host_addr = 6'h00;
        host_bank_addr_bit = 1'b0;
        host_data_bus_in = 8'h00;
    end

    task automatic port_cycle(input logic wr, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk);
        host_addr = {2'h0, idx};
        host_data_bus_in = wr ? d : ~host_data_bus_in;
        host_ctl.port_sel_n = 1'b0;
        host_ctl.io_wr_n = ~wr;
        host_ctl.io_rd_n = wr;
        @(posedge mclk);
        // Undriven bus reads back as garbage
        q = host_data_bus_oe_n ? ~host_data_bus_out : host_data_bus_out;
        @(negedge mclk);
        host_ctl = '1;
        host_data_bus_in = ~host_data_bus_in;
    endtask

    task automatic mem_cycle(input logic wr, input logic b14, input logic [5:0] a, input logic [7:0] d,
                             output logic [7:0] q, output int n);
        @(negedge mclk);
        host_addr = a;
        host_bank_addr_bit = b14;
        host_data_bus_in = wr ? d : ~host_data_bus_in;
        host_ctl.mem_sel_n = 1'b0;
        host_ctl.mem_wr_n = ~wr;
        host_ctl.mem_rd_n = wr;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (bus_ready_out !== 1'b1 && n < 8);
        q = host_data_bus_oe_n ? ~host_data_bus_out : host_data_bus_out;
        @(negedge mclk);
        host_ctl = '1;
        host_data_bus_in = ~host_data_bus_in;
    endtask
endmodule

//--- tb/display_vram_host_access_tb.sv
`timescale 1ns/10ps
module display_vram_host_access_tb;
    logic mclk, rst_n, controller_disable, refresh_req, internal_panel, raster_line_bit1, raster_line_bit0;
    logic [13:0] refresh_addr;
    logic [7:0] cval, aval, host_data_bus_in, host_data_bus_out, refresh_char, refresh_attr;
    logic [7:0] char_byte_bus_in, char_byte_bus_out, attr_byte_bus_in, attr_byte_bus_out, hcc, hat;
    logic [5:0] host_addr;
    logic [4:0] vram_low_addr, hla, rla;
    logic [6:0] refresh_addr_mid;
    logic [127:0] port_bank;
    logic host_bank_addr_bit, host_data_bus_oe_n, bus_ready_out, refresh_valid, graph_mode, box_tall, mode_ok;
    logic refresh_addr_bit12, char_byte_bus_oe_n, attr_byte_bus_oe_n;
    dvha_pkg::dvha_host_ctl_s host_ctl;
    dvha_pkg::dvha_vram_ctl_s vram_ctl, hsnap, rsnap;
    int num_errors = 0;
    int checks = 0;

    dvha_host_access dvha_host_access_i (.mclk, .rst_n, .host_ctl, .host_addr, .host_bank_addr_bit,
        .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n, .bus_ready_out, .controller_disable,
        .refresh_req, .refresh_addr, .raster_line_bit1, .raster_line_bit0, .internal_panel, .refresh_char,
        .refresh_attr, .refresh_valid, .graph_mode, .box_tall, .mode_ok, .port_bank, .vram_ctl, .vram_low_addr,
        .refresh_addr_bit12, .refresh_addr_mid, .char_byte_bus_in, .char_byte_bus_out, .char_byte_bus_oe_n,
        .attr_byte_bus_in, .attr_byte_bus_out, .attr_byte_bus_oe_n);
    dvha_host_model dvha_host_model_i (.mclk, .host_ctl, .host_addr, .host_bank_addr_bit, .host_data_bus_in,
        .host_data_bus_out, .host_data_bus_oe_n, .bus_ready_out);

    // Unselected RAM shows the inverse, not a stale byte
    assign char_byte_bus_in = (vram_ctl.bank_low_enable_n & vram_ctl.bank_high_enable_n) ? ~cval : cval;
    assign attr_byte_bus_in = (vram_ctl.bank_low_enable_n & vram_ctl.bank_high_enable_n) ? ~aval : aval;

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [7:0] pdat(input int i);
        return 8'(i * 29 + 3);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    always @(posedge mclk)
    begin
        if (rst_n === 1'b1)
        begin
            chk({7'h0, ~(vram_ctl.char_write_strobe_n & vram_ctl.attr_write_strobe_n)
                & (host_ctl.mem_sel_n | host_ctl.mem_wr_n | controller_disable)}, 8'h00, "stray strobe");
            chk({7'h0, ~bus_ready_out & (host_ctl.mem_sel_n | controller_disable)}, 8'h00, "ready low");
            chk({6'h0, vram_ctl.char_write_strobe_n ^ char_byte_bus_oe_n,
                vram_ctl.attr_write_strobe_n ^ attr_byte_bus_oe_n}, 8'h00, "ram drive");
            if (vram_ctl.addr_mux_select === 1'b1 && !(vram_ctl.bank_low_enable_n & vram_ctl.bank_high_enable_n))
            begin
                hsnap <= vram_ctl;
                hla <= vram_low_addr;
                hcc <= char_byte_bus_out;
                hat <= attr_byte_bus_out;
            end
            if (vram_ctl.addr_mux_select === 1'b0 && !(vram_ctl.bank_low_enable_n & vram_ctl.bank_high_enable_n))
            begin
                rsnap <= vram_ctl;
                rla <= vram_low_addr;
            end
        end
    end

    task automatic test_reset();
        chk({7'h0, bus_ready_out}, 8'h01, "reset ready");
        chk({7'h0, refresh_valid}, 8'h00, "reset valid");
        chk({7'h0, port_bank == 128'h0}, 8'h01, "reset ports");
        chk({4'h0, vram_ctl[3:0]}, 8'h0f, "reset ram ctl");
    endtask

    task automatic test_ports();
        logic [7:0] q;
        for (int i = 0; i < 16; i++)
            dvha_host_model_i.port_cycle(1'b1, 4'(i), pdat(i), q);
        for (int i = 0; i < 16; i++)
        begin
            dvha_host_model_i.port_cycle(1'b0, 4'(i), 8'h00, q);
            chk(q, pdat(i), "port read");
            chk(port_bank[i*8+:8], pdat(i), "port bank");
        end
    endtask

    task automatic test_mem();
        logic [7:0] q;
        logic [5:0] a;
        int n;
        for (int k = 0; k < 4; k++)
        begin
            a = {4'hb, k[1], k[0]};
            hsnap = '0;
            dvha_host_model_i.mem_cycle(1'b1, k[1], a, 8'h60 + 8'(k), q, n);
            chk(8'(n <= 4), 8'h01, "write wait");
            chk({3'h0, hsnap}, {3'h0, 1'b1, k[1], ~k[1], k[0], ~k[0]}, "write ctl");
            chk({3'h0, hla}, {3'h0, a[5:1]}, "write addr");
            chk(k[0] ? hat : hcc, 8'h60 + 8'(k), "write data");
            cval = 8'hc0 + 8'(k);
            aval = 8'h0c + 8'(k);
            hsnap = '0;
            dvha_host_model_i.mem_cycle(1'b0, k[1], a, 8'h00, q, n);
            chk(q, k[0] ? aval : cval, "read data");
            chk({3'h0, hsnap}, {3'h0, 1'b1, k[1], ~k[1], 2'h3}, "read ctl");
        end
    endtask

    task automatic test_refresh();
        logic [7:0] q, rc, rat;
        logic seen, bank;
        refresh_addr = 14'h2abc;
        raster_line_bit1 = 1'b0;
        raster_line_bit0 = 1'b1;
        cval = 8'h3c;
        aval = 8'hc3;
        for (int g = 0; g < 2; g++)
        begin
            dvha_host_model_i.port_cycle(1'b1, 4'h8, g ? 8'h02 : 8'h00, q);
            rsnap = '0;
            seen = 1'b0;
            bank = g ? raster_line_bit1 : refresh_addr[13];
            @(negedge mclk);
            refresh_req = 1'b1;
            @(negedge mclk);
            refresh_req = 1'b0;
            repeat (6)
            begin
                @(posedge mclk);
                if (refresh_valid === 1'b1)
                begin
                    seen = 1'b1;
                    rc = refresh_char;
                    rat = refresh_attr;
                end
            end
            chk({7'h0, seen}, 8'h01, "refresh done");
            chk(rc, cval, "refresh char");
            chk(rat, aval, "refresh attr");
            chk({3'h0, rsnap}, {3'h0, 1'b0, bank, ~bank, 2'h3}, "refresh ctl");
            chk({3'h0, rla}, {3'h0, refresh_addr[4:0]}, "refresh low");
            chk({7'h0, refresh_addr_bit12}, {7'h0, g ? raster_line_bit0 : refresh_addr[12]}, "bit12");
            chk({1'h0, refresh_addr_mid}, {1'h0, refresh_addr[11:5]}, "mid addr");
            chk({7'h0, graph_mode}, 8'(g), "graph");
        end
        dvha_host_model_i.port_cycle(1'b1, 4'h8, 8'h00, q);
    endtask

    task automatic test_collision();
        logic [7:0] q;
        int n;
        cval = 8'h99;
        rsnap = '0;
        fork
            dvha_host_model_i.mem_cycle(1'b0, 1'b0, 6'h00, 8'h00, q, n);
            begin
                @(negedge mclk);
                refresh_req = 1'b1;
                @(negedge mclk);
                refresh_req = 1'b0;
            end
        join
        chk(8'(n <= 4), 8'h01, "shared wait");
        chk(q, cval, "shared read");
        // Refresh fetch follows the host slot
        repeat (4) @(negedge mclk);
        chk({3'h0, rsnap}, 8'h0b, "shared refresh");
    endtask

    task automatic test_disable();
        logic [7:0] q;
        int n;
        controller_disable = 1'b1;
        hsnap = '0;
        dvha_host_model_i.port_cycle(1'b1, 4'h3, 8'hee, q);
        chk(port_bank[31:24], pdat(3), "disabled port");
        dvha_host_model_i.mem_cycle(1'b1, 1'b0, 6'h01, 8'h77, q, n);
        chk(8'(n), 8'h01, "disabled write");
        dvha_host_model_i.mem_cycle(1'b0, 1'b1, 6'h00, 8'h00, q, n);
        chk(8'(n), 8'h01, "disabled read");
        chk({3'h0, hsnap}, 8'h00, "disabled ram");
        controller_disable = 1'b0;
    endtask

    task automatic test_modes();
        logic [7:0] q;
        logic ok;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 8; c++)
            begin
                internal_panel = p[0];
                dvha_host_model_i.port_cycle(1'b1, 4'h8, 8'(c), q);
                ok = c != 7 && (p == 1 || c < 4);
                chk({7'h0, mode_ok}, 8'(ok), "mode ok");
                if (ok)
                begin
                    chk({7'h0, graph_mode}, 8'(c == 2 || c == 3 || c == 6), "mode graph");
                    chk({7'h0, box_tall}, 8'(p == 1 && (c < 2 || c == 6)), "mode box");
                end
            end
    endtask

    task automatic conclude();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        conclude();
    end

    initial
    begin
        rst_n = 1'b0;
        controller_disable = 1'b0;
        refresh_req = 1'b0;
        internal_panel = 1'b1;
        raster_line_bit1 = 1'b0;
        raster_line_bit0 = 1'b0;
        refresh_addr = 14'h0000;
        cval = 8'h00;
        aval = 8'h00;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        test_reset();
        test_ports();
        test_mem();
        test_refresh();
        test_collision();
        test_disable();
        test_modes();
        conclude();
    end
endmodule
